// ### design/spim_pkg.sv
/*
 * Shared constants, field layouts, carrier types and helper functions of the
 * serial peripheral port (master or slave, four chip selects).
 * Assumes a single 100 MHz system clock; no register bus, all controls are ports.
 */
`default_nettype none
package spim_pkg;

   // -----------------------------------------------------------------------
   // Transmit word layout
   // -----------------------------------------------------------------------
   localparam int DATA_W = 16;           // Widest serial word.
   localparam int TDR_W = 25;            // Transmit word width up to the final flag.
   localparam int FINAL_BIT = 24;        // Final transfer flag position.
   localparam int CS_LSB = 16;           // Chip-select index field, low bit.
   localparam int CS_W = 2;              // Chip-select index width.
   localparam int NCS = 4;               // Number of chip selects.

   // -----------------------------------------------------------------------
   // Configuration layout and reset values
   // -----------------------------------------------------------------------
   localparam int DIV_W = 8;             // Clock divisor width.
   localparam int LEN_W = 4;             // Word length code width.
   localparam logic [4:0] BITS_BASE = 5'h08;  // Code 0 means 8 bits.
   localparam logic [3:0] LEN_MAX = 4'h8;     // Code 8 means 16 bits.
   localparam logic [7:0] DIV_ONE = 8'h01;    // Divisor giving the fastest clock.
   localparam logic [5:0] EXTRA_PULSE = 6'h02;  // One surplus pulse is two edges.

   // -----------------------------------------------------------------------
   // Buffering and synchronisers
   // -----------------------------------------------------------------------
   localparam int FIFO_DEPTH = 32;       // Transmit buffer depth in words.
   localparam int SYNC_W = 4;            // Synchronised pins: sclk, mosi, miso, select.
   localparam int SY_SCLK = 0;
   localparam int SY_MOSI = 1;
   localparam int SY_MISO = 2;
   localparam int SY_SEL = 3;

   // Per chip select configuration, one register each.
   typedef struct packed {
      logic cs_hold_after_xfer;
      logic clk_capture_edge_sel;
      logic clk_idle_level;
      logic [DIV_W-1:0] clk_divisor;
      logic [LEN_W-1:0] word_len;
   } spim_cfg_t;

   localparam spim_cfg_t CFG_RST = '{1'b0, 1'b0, 1'b0, 8'h01, 4'h0};

   // Transmit word as it travels through the buffer.
   typedef struct packed {
      logic from_dma;
      logic [TDR_W-1:0] word;
   } spim_txw_t;

   localparam int TXW_W = TDR_W + 1;

   // Engine states, one-hot.
   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_SETUP = 4'b0010,
      ST_SHIFT = 4'b0100,
      ST_HOLD  = 4'b1000
   } spim_state_t;

   // Number of bits in a word from its length code; out-of-range codes mean 8.
   function automatic logic [4:0] spim_bits(input logic [LEN_W-1:0] code);
      spim_bits = (code > LEN_MAX) ? BITS_BASE : BITS_BASE + {1'b0, code};
   endfunction

   // Chip-select index carried in a transmit word.
   function automatic logic [CS_W-1:0] spim_cs(input logic [TDR_W-1:0] w);
      spim_cs = w[CS_LSB +: CS_W];
   endfunction

endpackage
`default_nettype wire

// ### design/spim_fifo.sv
/*
 * Synchronous FIFO with parameter width and depth, valid/ready on both sides.
 * Read data come out of a register. Assumes one clock, active-low async reset.
 */
`timescale 1ns/1ns
`default_nettype none
module spim_fifo #(
   parameter int WIDTH = 26,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic flush_in,
   // Fill side
   input wire logic in_valid_in,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic in_ready_out,
   // Drain side
   output logic out_valid_out,
   output logic [WIDTH-1:0] out_data_out,
   input wire logic out_ready_in
);
   localparam int AW = $clog2(DEPTH);

   // -----------------------------------------------------------------------
   // Storage and pointers
   // -----------------------------------------------------------------------
   logic [WIDTH-1:0] mem_r [DEPTH];      // Word storage.
   logic [AW-1:0] wr_r, wr_nxt;          // Write pointer.
   logic [AW-1:0] rd_r, rd_nxt;          // Read pointer.
   logic [AW:0] cnt_r, cnt_nxt;          // Words in storage, not the output stage.
   logic ready_r, ready_nxt;             // Registered room flag.
   logic oval_r, oval_nxt;               // Output stage holds a word.
   logic [WIDTH-1:0] odat_r, odat_nxt;   // Output stage data.
   logic push, pop;

   // Next pointers, count and output stage.
   always_comb begin
      push = in_valid_in && ready_r;
      pop = (cnt_r != '0) && (!oval_r || out_ready_in);
      wr_nxt = push ? wr_r + 1'b1 : wr_r;
      rd_nxt = pop ? rd_r + 1'b1 : rd_r;
      cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      oval_nxt = pop ? 1'b1 : (out_ready_in ? 1'b0 : oval_r);
      odat_nxt = pop ? mem_r[rd_r] : odat_r;
      // Room counts the output stage too, so exactly DEPTH words fit.
      ready_nxt = ((cnt_nxt + {{AW{1'b0}}, oval_nxt}) != DEPTH[AW:0]);
      if (flush_in) begin
         wr_nxt = '0;
         rd_nxt = '0;
         cnt_nxt = '0;
         oval_nxt = 1'b0;
         ready_nxt = 1'b1;
      end
   end

   // State registers.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_r <= '0;
         rd_r <= '0;
         cnt_r <= '0;
         ready_r <= 1'b0;
         oval_r <= 1'b0;
         odat_r <= '0;
      end else begin
         wr_r <= wr_nxt;
         rd_r <= rd_nxt;
         cnt_r <= cnt_nxt;
         ready_r <= ready_nxt;
         oval_r <= oval_nxt;
         odat_r <= odat_nxt;
      end
   end

   // Memory write; no reset so it maps onto RAM.
   always_ff @(posedge clk_in) begin
      if (push && !flush_in) begin
         mem_r[wr_r] <= in_data_in;
      end
   end

   assign in_ready_out = ready_r;
   assign out_valid_out = oval_r;
   assign out_data_out = odat_r;
endmodule // spim_fifo
`default_nettype wire

// ### design/spim_port.sv
/*
 * Serial peripheral port, master or slave, four chip selects, per-select
 * configuration, transmit FIFO. Pins are sampled through two flip-flops.
 * Assumes 100 MHz clk_in; the link clock is sampled as ordinary data.
 */
`timescale 1ns/1ns
`default_nettype none
module spim_port
   import spim_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // Control
   input wire logic soft_reset_cmd_in,
   input wire logic enable_in,
   input wire logic disable_in,
   input wire logic master_select_in,
   input wire logic fixed_mode_in,
   input wire logic [CS_W-1:0] fixed_cs_in,
   // Configuration write
   input wire logic cfg_wr_in,
   input wire logic [CS_W-1:0] cfg_idx_in,
   input wire spim_cfg_t cfg_data_in,
   // Transmit stream
   input wire logic tx_valid_in,
   input wire spim_txw_t tx_data_in,
   output logic tx_ready_out,
   // Receive and status
   output logic rx_valid_out,
   output logic [DATA_W-1:0] rx_data_out,
   input wire logic rx_ready_in,
   output logic enabled_out,
   output logic tx_slot_free_out,
   output logic tx_drained_flag_out,
   output logic xfer_halfword_out,
   // Serial pins
   input wire logic serial_clk_in,
   output logic serial_clk_out,
   output logic serial_clk_oe_out,
   input wire logic mosi_in,
   output logic mosi_out,
   output logic mosi_oe_out,
   input wire logic miso_in,
   output logic miso_out,
   output logic miso_oe_out,
   input wire logic slave_sel_n_in,
   output logic [NCS-1:0] cs_n_out
);

   // -----------------------------------------------------------------------
   // Reset release and pin synchronisers
   // -----------------------------------------------------------------------
   logic [1:0] rst_sync_r;               // Reset release chain.
   logic rst_n;                          // Released reset for the design.
   logic [SYNC_W-1:0] sy1_r, sy2_r;      // Two-stage pin synchronisers.
   logic sclk_d3_r;                      // Delayed copy for edge finding.

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rst_sync_r <= 2'b00;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   // The first stage feeds only the second stage.
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         sy1_r <= '0;
         sy2_r <= '0;
         sclk_d3_r <= 1'b0;
      end else begin
         sy1_r <= {slave_sel_n_in, miso_in, mosi_in, serial_clk_in};
         sy2_r <= sy1_r;
         sclk_d3_r <= sy2_r[SY_SCLK];
      end
   end

   // -----------------------------------------------------------------------
   // Transmit FIFO
   // -----------------------------------------------------------------------
   logic fifo_valid;
   spim_txw_t fifo_word;
   logic fifo_pop;
   logic fifo_ready;

   spim_fifo #(.WIDTH(TXW_W), .DEPTH(FIFO_DEPTH)) u_txq (
      .clk_in(clk_in),
      .rst_n_in(rst_n),
      .flush_in(soft_reset_cmd_in),
      .in_valid_in(tx_valid_in),
      .in_data_in(tx_data_in),
      .in_ready_out(fifo_ready),
      .out_valid_out(fifo_valid),
      .out_data_out(fifo_word),
      .out_ready_in(fifo_pop)
   );
   assign tx_ready_out = fifo_ready;

   // -----------------------------------------------------------------------
   // Configuration and engine state
   // -----------------------------------------------------------------------
   spim_cfg_t cfg_r [NCS];               // Per-select configuration.
   spim_cfg_t cfg_nxt [NCS];
   logic en_r, en_nxt;                   // Port enabled.
   logic mst_r, mst_nxt;                 // Master mode.
   spim_state_t st_r, st_nxt;            // Engine state.
   logic [DIV_W-1:0] cnt_r, cnt_nxt;     // Divider count.
   logic [5:0] edge_r, edge_nxt;         // Clock edges done in this word.
   logic [5:0] tot_r, tot_nxt;           // Edges this word takes.
   logic [4:0] bits_r, bits_nxt;         // Data bits this word.
   logic [DATA_W-1:0] tsh_r, tsh_nxt;    // Transmit shifter, left aligned.
   logic [DATA_W-1:0] rsh_r, rsh_nxt;    // Receive shifter.
   logic [CS_W-1:0] cur_r, cur_nxt;      // Active chip select.
   logic [CS_W-1:0] prv_r, prv_nxt;      // Previous word's select.
   logic prv_slow_r, prv_slow_nxt;       // Previous word used a divisor other than one.
   logic idle_seen_r, idle_seen_nxt;     // Idle gap while select was held.
   logic fin_r, fin_nxt;                 // Current word carries the final flag.
   logic glitch_r, glitch_nxt;           // Early clock toggle pending.
   logic sclk_r, sclk_nxt, mosi_r, mosi_nxt, miso_r, miso_nxt;
   logic [NCS-1:0] csn_r, csn_nxt;
   logic rxv_r, rxv_nxt;
   logic [DATA_W-1:0] rxd_r, rxd_nxt;
   logic slot_r, slot_nxt, drn_r, drn_nxt, hw_r, hw_nxt;
   spim_cfg_t cc;                        // Configuration of the active select.
   logic tick, sedge, lead, data_edge, capt, word_end;
   logic [CS_W-1:0] want_cs;
   logic [CS_W-1:0] hw_cs;

   // Engine next-state logic.
   always_comb begin
      for (int i = 0; i < NCS; i++) begin
         cfg_nxt[i] = cfg_r[i];
      end
      en_nxt = en_r;
      mst_nxt = master_select_in;
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      edge_nxt = edge_r;
      tot_nxt = tot_r;
      bits_nxt = bits_r;
      tsh_nxt = tsh_r;
      rsh_nxt = rsh_r;
      cur_nxt = cur_r;
      prv_nxt = prv_r;
      prv_slow_nxt = prv_slow_r;
      idle_seen_nxt = idle_seen_r;
      fin_nxt = fin_r;
      glitch_nxt = glitch_r;
      sclk_nxt = sclk_r;
      mosi_nxt = mosi_r;
      miso_nxt = miso_r;
      csn_nxt = csn_r;
      rxv_nxt = rx_ready_in ? 1'b0 : rxv_r;
      rxd_nxt = rxd_r;
      slot_nxt = 1'b0;
      fifo_pop = 1'b0;
      cc = cfg_r[cur_r];
      // Divided clock tick: one half period is clk_divisor system cycles.
      tick = (cnt_r >= cc.clk_divisor - DIV_ONE) || (cc.clk_divisor == '0);
      cnt_nxt = tick ? '0 : cnt_r + 1'b1;
      // Slave edge from the synchronised link clock.
      sedge = mst_r ? tick : (sy2_r[SY_SCLK] != sclk_d3_r);
      lead = (edge_r[0] == 1'b0);
      data_edge = (edge_r < {bits_r, 1'b0});
      capt = data_edge && (cc.clk_capture_edge_sel ? lead : !lead);
      word_end = (edge_r == tot_r - 6'h01);
      want_cs = fixed_mode_in ? fixed_cs_in : spim_cs(fifo_word.word);
      // Fixed-mode DMA width always looks at select zero.
      hw_cs = fixed_mode_in ? '0 : want_cs;
      hw_nxt = (spim_bits(cfg_r[hw_cs].word_len) > BITS_BASE);
      drn_nxt = !fifo_valid && (st_r == ST_IDLE || st_r == ST_HOLD);
      // Each select keeps its own configuration word.
      if (cfg_wr_in) begin
         cfg_nxt[cfg_idx_in] = cfg_data_in;
         // Configuring while still slave leaves a stray toggle pending.
         glitch_nxt = !master_select_in;
      end
      if (enable_in) begin
         en_nxt = 1'b1;
      end
      // A disable request only takes effect in master mode.
      if (disable_in && mst_r) begin
         en_nxt = 1'b0;
      end
      case (st_r)
         ST_IDLE: begin
            csn_nxt = '1;
            sclk_nxt = cfg_r[mst_r ? want_cs : '0].clk_idle_level;
            // Master toggles once before any transfer if configured early; with a divisor above one it pulses on every idle tick.
            if (mst_r && glitch_r && tick) begin
               sclk_nxt = ~sclk_r;
               glitch_nxt = (sclk_r == cc.clk_idle_level);
            end
            if (en_r && fifo_valid && mst_r) begin
               cur_nxt = want_cs;
               st_nxt = ST_SETUP;
            end else if (en_r && !mst_r && !sy2_r[SY_SEL]) begin
               cur_nxt = '0;
               st_nxt = ST_SETUP;
            end
         end
         ST_SETUP: begin
            if (mst_r) begin
               csn_nxt = ~(4'h1 << cur_r);
            end
            bits_nxt = spim_bits(cc.word_len);
            tot_nxt = {bits_nxt, 1'b0};
            // Divisor one with an odd length adds one pulse; even is clean.
            if (cc.clk_divisor == DIV_ONE && bits_nxt[0]) begin
               tot_nxt = tot_nxt + EXTRA_PULSE;
            end
            // Slow select then divisor one in idle-high, edge-select zero.
            if (mst_r && cc.clk_idle_level && !cc.clk_capture_edge_sel
                && cc.clk_divisor == DIV_ONE && prv_slow_r && prv_r != cur_r) begin
               tot_nxt = tot_nxt + EXTRA_PULSE;
            end
            tsh_nxt = '0;
            fin_nxt = 1'b0;
            if (fifo_valid) begin
               fifo_pop = 1'b1;
               tsh_nxt = fifo_word.word[DATA_W-1:0] << (5'h10 - bits_nxt);
               fin_nxt = fifo_word.word[FINAL_BIT];
               // Second word to the same held slave after a gap at divisor one: no slot free.
               slot_nxt = !(cc.cs_hold_after_xfer && cc.clk_divisor == DIV_ONE
                            && idle_seen_r && prv_r == cur_r);
            end
            edge_nxt = '0;
            rsh_nxt = '0;
            mosi_nxt = tsh_nxt[DATA_W-1];
            miso_nxt = tsh_nxt[DATA_W-1];
            cnt_nxt = '0;
            sclk_nxt = cc.clk_idle_level;
            st_nxt = ST_SHIFT;
         end
         ST_SHIFT: begin
            if (!mst_r && sy2_r[SY_SEL]) begin
               st_nxt = ST_IDLE;
            end else if (sedge) begin
               if (mst_r) begin
                  sclk_nxt = ~sclk_r;
               end
               edge_nxt = edge_r + 6'h01;
               if (capt) begin
                  rsh_nxt = {rsh_r[DATA_W-2:0], mst_r ? sy2_r[SY_MISO] : sy2_r[SY_MOSI]};
               end
               // Data change on the edge that does not capture.
               if (data_edge && !capt) begin
                  if (cc.clk_capture_edge_sel) begin
                     tsh_nxt = tsh_r << 1;
                     mosi_nxt = tsh_r[DATA_W-2];
                     miso_nxt = tsh_r[DATA_W-2];
                  end else begin
                     mosi_nxt = tsh_r[DATA_W-1];
                     miso_nxt = tsh_r[DATA_W-1];
                     tsh_nxt = tsh_r << 1;
                  end
               end
               if (word_end) begin
                  rxd_nxt = rsh_nxt;
                  rxv_nxt = 1'b1;
                  prv_nxt = cur_r;
                  prv_slow_nxt = (cc.clk_divisor != DIV_ONE);
                  idle_seen_nxt = 1'b0;
                  if (!mst_r) begin
                     st_nxt = ST_SETUP;
                  // A word with the final flag releases the select at its word end.
                  end else if (cc.cs_hold_after_xfer && !fin_r) begin
                     st_nxt = ST_HOLD;
                  end else begin
                     st_nxt = ST_IDLE;
                  end
               end
            end
         end
         ST_HOLD: begin
            sclk_nxt = cc.clk_idle_level;
            if (!en_r || (fifo_valid && want_cs != cur_r)) begin
               st_nxt = ST_IDLE;
            end else if (fifo_valid) begin
               st_nxt = ST_SETUP;
            end else begin
               idle_seen_nxt = 1'b1;
            end
         end
         default: begin
            st_nxt = ST_IDLE;
         end
      endcase
      // Soft reset returns configuration, enable, state, selects, clock, rx valid and the glitch, slow and idle-gap flags to their reset values.
      if (soft_reset_cmd_in) begin
         for (int i = 0; i < NCS; i++) begin
            cfg_nxt[i] = CFG_RST;
         end
         en_nxt = 1'b0;
         st_nxt = ST_IDLE;
         csn_nxt = '1;
         rxv_nxt = 1'b0;
         glitch_nxt = 1'b0;
         prv_slow_nxt = 1'b0;
         idle_seen_nxt = 1'b0;
         sclk_nxt = CFG_RST.clk_idle_level;
      end
   end

   // Engine registers.
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < NCS; i++) begin
            cfg_r[i] <= CFG_RST;
         end
         en_r <= 1'b0;
         mst_r <= 1'b0;
         st_r <= ST_IDLE;
         cnt_r <= '0;
         edge_r <= '0;
         tot_r <= '0;
         bits_r <= BITS_BASE;
         tsh_r <= '0;
         rsh_r <= '0;
         cur_r <= '0;
         prv_r <= '0;
         prv_slow_r <= 1'b0;
         idle_seen_r <= 1'b0;
         fin_r <= 1'b0;
         glitch_r <= 1'b0;
         sclk_r <= 1'b0;
         mosi_r <= 1'b0;
         miso_r <= 1'b0;
         csn_r <= '1;
         rxv_r <= 1'b0;
         rxd_r <= '0;
         slot_r <= 1'b0;
         drn_r <= 1'b0;
         hw_r <= 1'b0;
      end else begin
         for (int i = 0; i < NCS; i++) begin
            cfg_r[i] <= cfg_nxt[i];
         end
         en_r <= en_nxt;
         mst_r <= mst_nxt;
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         edge_r <= edge_nxt;
         tot_r <= tot_nxt;
         bits_r <= bits_nxt;
         tsh_r <= tsh_nxt;
         rsh_r <= rsh_nxt;
         cur_r <= cur_nxt;
         prv_r <= prv_nxt;
         prv_slow_r <= prv_slow_nxt;
         idle_seen_r <= idle_seen_nxt;
         fin_r <= fin_nxt;
         glitch_r <= glitch_nxt;
         sclk_r <= sclk_nxt;
         mosi_r <= mosi_nxt;
         miso_r <= miso_nxt;
         csn_r <= csn_nxt;
         rxv_r <= rxv_nxt;
         rxd_r <= rxd_nxt;
         slot_r <= slot_nxt;
         drn_r <= drn_nxt;
         hw_r <= hw_nxt;
      end
   end

   // -----------------------------------------------------------------------
   // Outputs, all straight from flip-flops
   // -----------------------------------------------------------------------
   assign rx_valid_out = rxv_r;
   assign rx_data_out = rxd_r;
   assign enabled_out = en_r;
   assign tx_slot_free_out = slot_r;
   assign tx_drained_flag_out = drn_r;
   assign xfer_halfword_out = hw_r;
   assign serial_clk_out = sclk_r;
   assign serial_clk_oe_out = mst_r;
   assign mosi_out = mosi_r;
   assign mosi_oe_out = mst_r;
   assign miso_out = miso_r;
   assign miso_oe_out = en_r;
   assign cs_n_out = csn_r;
endmodule // spim_port
`default_nettype wire

// ### testbench/spim_port_assertions.sv
/* Checker of the port's outputs against its inputs.
   Assumes a bind into spim_port. */
`timescale 1ns/1ns
`default_nettype none
module spim_port_assertions
   import spim_pkg::*;
(
   // Inputs seen
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic soft_reset_cmd_in,
   input wire logic disable_in,
   input wire logic master_select_in,
   input wire logic fixed_mode_in,
   input wire logic cfg_wr_in,
   input wire logic [CS_W-1:0] cfg_idx_in,
   input wire spim_cfg_t cfg_data_in,
   input wire logic rx_ready_in,
   // Outputs seen
   input wire logic rx_valid_out,
   input wire logic [DATA_W-1:0] rx_data_out,
   input wire logic enabled_out,
   input wire logic tx_slot_free_out,
   input wire logic xfer_halfword_out,
   input wire logic serial_clk_oe_out,
   input wire logic mosi_oe_out,
   input wire logic [NCS-1:0] cs_n_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   // Shadow of select zero's length; a soft reset clears it as well.
   logic [LEN_W-1:0] len0_r;
   logic [LEN_W-1:0] len0_nxt;
   always_comb begin
      len0_nxt = len0_r;
      if (soft_reset_cmd_in) len0_nxt = '0;
      else if (cfg_wr_in && cfg_idx_in == '0) len0_nxt = cfg_data_in.word_len;
   end
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) len0_r <= '0;
      else len0_r <= len0_nxt;
   end
   slot_free_pulse_a: assert property (tx_slot_free_out |=> !tx_slot_free_out)
      else $error("slot free too long");
   cs_one_hot_a: assert property ($onehot0(~cs_n_out))
      else $error("two selects low");
   slave_disable_a: assert property (disable_in && !master_select_in
      && !$past(master_select_in) && !soft_reset_cmd_in && enabled_out |=> enabled_out)
      else $error("slave disabled");
   halfword_cs0_a: assert property (fixed_mode_in && $past(fixed_mode_in)
      && len0_r == $past(len0_r) |-> xfer_halfword_out == (len0_r != '0 && len0_r <= LEN_MAX))
      else $error("width not from select zero");
   rx_hold_a: assert property (rx_valid_out && !rx_ready_in && !soft_reset_cmd_in
      |=> rx_valid_out && $stable(rx_data_out))
      else $error("rx word dropped");
   oe_pair_a: assert property (serial_clk_oe_out == mosi_oe_out
      && mosi_oe_out == $past(master_select_in))
      else $error("enables differ");
   soft_reset_off_a: assert property (soft_reset_cmd_in |=> !enabled_out)
      else $error("soft reset kept port on");
   idle_no_start_a: assert property (!enabled_out && &cs_n_out |=> &cs_n_out)
      else $error("word started while off");
   cover property (rx_valid_out && !rx_ready_in);
   cover property (tx_slot_free_out);
   cover property (xfer_halfword_out && fixed_mode_in);
endmodule // spim_port_assertions
`default_nettype wire

// ### testbench/spim_slave_model.sv
/* Serial slave on the far side of the selects.
   Assumes it samples the pins on clk_in. */
`timescale 1ns/1ns
`default_nettype none
module spim_slave_model (
   // Clock and pins
   input wire logic clk_in,
   input wire logic [3:0] cs_n,
   input wire logic sclk,
   input wire logic mosi,
   output logic miso,
   // Last frame: clock edges and bits caught
   output int edges,
   output logic [15:0] word
);
   logic sel_r = 1'b0;
   logic sclk_r = 1'b0;
   int cnt = 0;
   logic [15:0] sr = '0;
   initial begin
      miso = 1'b0;
      edges = 0;
      word = '0;
   end
   // Counts edges while selected; catches data on rising clock edges.
   always @(posedge clk_in) begin
      if (!(&cs_n) && sclk != sclk_r) cnt <= cnt + 1;
      if (!(&cs_n) && sclk && !sclk_r) sr <= {sr[14:0], mosi};
      if (sel_r && &cs_n) begin
         edges <= cnt;
         word <= sr;
         cnt <= 0;
      end
      // Unselected, the line wanders, so a stale bit is never mistaken.
      miso <= (&cs_n) ? ~miso : sr[0];
      sel_r <= !(&cs_n);
      sclk_r <= sclk;
   end
endmodule // spim_slave_model
`default_nettype wire

// ### testbench/tb.sv
/* Bench of spim_port with a slave model.
   Assumes 100 MHz; inputs change at falling edges. */
`timescale 1ns/1ns
`default_nettype none
module tb;
   import spim_pkg::*;
   logic clk_in = 0, nrst_in = 0, soft_reset_cmd_in = 0, enable_in = 0, disable_in = 0;
   logic master_select_in = 0, fixed_mode_in = 0, cfg_wr_in = 0, tx_valid_in = 0;
   logic rx_ready_in = 0, serial_clk_in = 0, mosi_in = 1, slave_sel_n_in = 1, miso_in;
   logic [CS_W-1:0] fixed_cs_in = 0, cfg_idx_in = 0;
   spim_cfg_t cfg_data_in = CFG_RST;
   spim_txw_t tx_data_in = '0;
   logic tx_ready_out, rx_valid_out, enabled_out, tx_slot_free_out, tx_drained_flag_out;
   logic xfer_halfword_out, serial_clk_out, serial_clk_oe_out, mosi_out, mosi_oe_out;
   logic miso_out, miso_oe_out;
   logic [DATA_W-1:0] rx_data_out;
   logic [NCS-1:0] cs_n_out;
   logic [15:0] word;
   int mismatches = 0, tests_run = 0, cyc = 0, edges, b, m;
   int divs[4] = '{1, 1, 2, 3};
   int lens[4] = '{0, 1, 8, 2};
   spim_port spim_port_inst (.*);
   spim_slave_model spim_slave_model_inst (.clk_in, .cs_n(cs_n_out), .sclk(serial_clk_out),
      .mosi(mosi_out), .miso(miso_in), .edges, .word);
   initial forever #5 clk_in = ~clk_in;
   task automatic chk(input string what, input logic [31:0] exp, got);
      tests_run++;
      if (exp !== got) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic pulse(ref logic s);
      s = 1;
      @(negedge clk_in) s = 0;
      @(negedge clk_in);
   endtask
   task automatic cfg(input int i, input spim_cfg_t c);
      cfg_idx_in = CS_W'(i);
      cfg_data_in = c;
      pulse(cfg_wr_in);
   endtask
   // Leaves valid high so that back-to-back pushes go in one word per cycle.
   task automatic push(input logic [24:0] w);
      tx_data_in = {1'b1, w};
      tx_valid_in = 1;
      while (!tx_ready_out) @(negedge clk_in);
      @(negedge clk_in);
   endtask
   task automatic wait_word;
      tx_valid_in = 0;
      for (int k = 0; k < 3000 && !rx_valid_out; k++) @(negedge clk_in);
      repeat (3) @(negedge clk_in);
   endtask
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         end_sim;
      end
   end
   initial begin
      repeat (16) @(negedge clk_in);
      nrst_in = 1;
      repeat (6) @(negedge clk_in);
      master_select_in = 1;
      @(negedge clk_in);
      pulse(enable_in);
      for (int i = 0; i < 4; i++) begin
         cfg(i, '{1'b0, 1'b1, 1'b0, 8'(divs[i]), 4'(lens[i])});
         push({7'h00, 2'(i), 16'hA5C3});
         wait_word();
         b = 8 + lens[i];
         m = (1 << b) - 1;
         chk("edges", 2 * b + ((divs[i] == 1 && b % 2) ? 2 : 0), edges);
         if (!(divs[i] == 1 && b % 2)) chk("mosi", 16'hA5C3 & m, word & m);
         if (i == 0) chk("rx held", 1, rx_valid_out);
         rx_ready_in = 1;
      end
      cfg(0, '{1'b0, 1'b1, 1'b0, 8'h02, 4'h2});
      cfg(1, '{1'b1, 1'b1, 1'b0, 8'h02, 4'h0});
      fixed_cs_in = 1;
      fixed_mode_in = 1;
      repeat (4) @(negedge clk_in);
      chk("halfword", 1, xfer_halfword_out);
      push({9'h001, 16'h1234});
      wait_word();
      chk("cs held", 4'hD, cs_n_out);
      push({1'b1, 8'h01, 16'h5678});
      wait_word();
      chk("cs freed", 4'hF, cs_n_out);
      cfg(0, '{1'b0, 1'b1, 1'b0, 8'h02, 4'h0});
      repeat (4) @(negedge clk_in);
      chk("halfword", 0, xfer_halfword_out);
      pulse(disable_in);
      chk("master off", 0, enabled_out);
      for (int j = 0; j < 32; j++) push({9'h001, 16'(j)});
      tx_valid_in = 0;
      @(negedge clk_in);
      chk("full", 0, tx_ready_out);
      pulse(soft_reset_cmd_in);
      pulse(soft_reset_cmd_in);
      repeat (4) @(negedge clk_in);
      chk("flushed", 1, tx_ready_out & tx_drained_flag_out);
      master_select_in = 0;
      fixed_mode_in = 0;
      rx_ready_in = 0;
      repeat (3) @(negedge clk_in);
      pulse(enable_in);
      slave_sel_n_in = 0;
      repeat (16) #40 serial_clk_in = ~serial_clk_in;
      #40 slave_sel_n_in = 1;
      @(negedge clk_in);
      pulse(disable_in);
      chk("slave on", 1, enabled_out);
      chk("slave data", 16'h00FF, rx_data_out);
      pulse(soft_reset_cmd_in);
      pulse(soft_reset_cmd_in);
      chk("stopped", 0, enabled_out);
      end_sim;
   end
endmodule // tb
bind spim_port spim_port_assertions spim_port_assertions_inst (.*);
`default_nettype wire
